// [design/psr_soft_reset_bank.sv]
// Peripheral soft-reset bank: two reset-control registers on AHB-Lite
// Behaviour
// - Writes to control A bits ignored where capability mask two marks unit absent.
// - Writes to control B bits ignored where capability mask four marks port absent.
// - Both registers clear to zero on system reset.
// - Bit 24 of control A resets comparator zero.
// - Bits 18, 17, 16 of control A reset counters two, one, zero.
// - Bit 12 of control A resets two-wire unit zero.
// - Bit 4 of control A resets synchronous serial unit zero.
// - Bits 1 and 0 of control A reset async serial one and zero.
// - Bits 4 to 0 of control B reset I/O ports E to A.
// - Unassigned bits are read-only zero; software preserves them.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module psr_soft_reset_bank
    import psr_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Capability masks, one bit per present unit
    input wire logic [31:0] capabilityMaskTwo,
    input wire logic [31:0] capabilityMaskFour,
    // Reset controls to peripherals, active high
    output psr_unit_rst_t unitRst,
    output psr_port_rst_t portRst
);
    logic [31:0] ctrlA_q;
    logic [31:0] ctrlB_q;
    logic [31:0] ctrlA_d;
    logic [31:0] ctrlB_d;
    logic wrPend_q;
    logic [11:0] wrAddr_q;

    // Present bits take the new value; the rest keep the old one
    function automatic logic [31:0] mergeMasked(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [31:0] wrMask
    );
        return (oldVal & ~wrMask) | (newVal & wrMask);
    endfunction : mergeMasked

    // Unmapped offsets and reserved bits read as zero
    function automatic logic [31:0] readMux(
        input logic [11:0] addr,
        input logic [31:0] regA,
        input logic [31:0] regB
    );
        logic [31:0] value;
        if (addr == PSR_OFF_CTRL_A) begin
            value = regA & PSR_IMPL_MASK_A;
        end else if (addr == PSR_OFF_CTRL_B) begin
            value = regB & PSR_IMPL_MASK_B;
        end else begin
            value = 32'h00000000;
        end
        return value;
    endfunction : readMux

    // Address phase capture; writes land in the data phase
    wire logic addrPhase = hsel && hready && htrans[1];
    wire logic hitA = (wrAddr_q == PSR_OFF_CTRL_A);
    wire logic hitB = (wrAddr_q == PSR_OFF_CTRL_B);
    wire logic [31:0] wrMaskA = PSR_IMPL_MASK_A & capabilityMaskTwo;
    wire logic [31:0] wrMaskB = PSR_IMPL_MASK_B & capabilityMaskFour;

    // Absent units keep their old bit; reserved bits stay zero
    assign ctrlA_d = (wrPend_q && hitA) ?
        mergeMasked(ctrlA_q, hwdata, wrMaskA) : ctrlA_q;
    assign ctrlB_d = (wrPend_q && hitB) ?
        mergeMasked(ctrlB_q, hwdata, wrMaskB) : ctrlB_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 12'h000;
        end else if (hready) begin
            wrPend_q <= addrPhase && hwrite;
            wrAddr_q <= haddr;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrlA_q <= PSR_RESET_VALUE;
            ctrlB_q <= PSR_RESET_VALUE;
        end else begin
            ctrlA_q <= ctrlA_d;
            ctrlB_q <= ctrlB_d;
        end
    end

    // Read data registered at the address phase; unmapped reads give zero
    wire logic [31:0] rdSel = readMux(haddr, ctrlA_q, ctrlB_q);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= rdSel;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Reset outputs follow the register bits directly
    assign unitRst = '{
        comparatorZero: ctrlA_q[PSR_BIT_CMP_ZERO],
        gpCounterTwo: ctrlA_q[PSR_BIT_CNT_TWO],
        gpCounterOne: ctrlA_q[PSR_BIT_CNT_ONE],
        gpCounterZero: ctrlA_q[PSR_BIT_CNT_ZERO],
        twoWireZero: ctrlA_q[PSR_BIT_TWOWIRE0],
        syncSerialZero: ctrlA_q[PSR_BIT_SYNCSER0],
        asyncSerialOne: ctrlA_q[PSR_BIT_ASYNC1],
        asyncSerialZero: ctrlA_q[PSR_BIT_ASYNC0]
    };
    assign portRst = ctrlB_q[4:0];

    property p_maskA;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitA)
            |=> (ctrlA_q & ~$past(wrMaskA)) == ($past(ctrlA_q) & ~$past(wrMaskA));
    endproperty
    a_maskA: assert property (p_maskA) else $error("absent unit bit changed");

    property p_maskB;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitB)
            |=> (ctrlB_q & ~$past(wrMaskB)) == ($past(ctrlB_q) & ~$past(wrMaskB));
    endproperty
    a_maskB: assert property (p_maskB) else $error("absent port bit changed");

    property p_writeA;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitA)
            |=> (ctrlA_q & $past(wrMaskA)) == ($past(hwdata) & $past(wrMaskA));
    endproperty
    a_writeA: assert property (p_writeA) else $error("control A write lost");

    property p_writeB;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitB)
            |=> (ctrlB_q & $past(wrMaskB)) == ($past(hwdata) & $past(wrMaskB));
    endproperty
    a_writeB: assert property (p_writeB) else $error("control B write lost");

    property p_resvA;
        @(posedge core_clk) disable iff (rst)
        (ctrlA_q & ~PSR_IMPL_MASK_A) == 32'h00000000;
    endproperty
    a_resvA: assert property (p_resvA) else $error("reserved A bit set");

    property p_resvB;
        @(posedge core_clk) disable iff (rst)
        (ctrlB_q & ~PSR_IMPL_MASK_B) == 32'h00000000;
    endproperty
    a_resvB: assert property (p_resvB) else $error("reserved B bit set");

    property p_hold;
        @(posedge core_clk) disable iff (rst)
        !wrPend_q |=> $stable(ctrlA_q) && $stable(ctrlB_q);
    endproperty
    a_hold: assert property (p_hold) else $error("reset bit moved without write");

    property p_readA;
        @(posedge core_clk) disable iff (rst)
        (addrPhase && !hwrite && haddr == PSR_OFF_CTRL_A && !wrPend_q)
            |=> hrdata == $past(ctrlA_q);
    endproperty
    a_readA: assert property (p_readA) else $error("control A readback wrong");

    property p_outs;
        @(posedge core_clk) disable iff (rst)
        unitRst.comparatorZero == ctrlA_q[PSR_BIT_CMP_ZERO]
            && unitRst.gpCounterTwo == ctrlA_q[PSR_BIT_CNT_TWO]
            && unitRst.asyncSerialZero == ctrlA_q[PSR_BIT_ASYNC0] && portRst.ioPortE == ctrlB_q[4];
    endproperty
    a_outs: assert property (p_outs) else $error("reset output mismatch");

    property p_wrCmp;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitA && capabilityMaskTwo[PSR_BIT_CMP_ZERO])
            |=> unitRst.comparatorZero == $past(hwdata[PSR_BIT_CMP_ZERO]);
    endproperty
    a_wrCmp: assert property (p_wrCmp) else $error("comparator reset wrong");

    property p_wrCntTwo;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitA && capabilityMaskTwo[PSR_BIT_CNT_TWO])
            |=> unitRst.gpCounterTwo == $past(hwdata[PSR_BIT_CNT_TWO]);
    endproperty
    a_wrCntTwo: assert property (p_wrCntTwo) else $error("counter two reset wrong");

    property p_wrCntOne;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitA && capabilityMaskTwo[PSR_BIT_CNT_ONE])
            |=> unitRst.gpCounterOne == $past(hwdata[PSR_BIT_CNT_ONE]);
    endproperty
    a_wrCntOne: assert property (p_wrCntOne) else $error("counter one reset wrong");

    property p_wrCntZero;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitA && capabilityMaskTwo[PSR_BIT_CNT_ZERO])
            |=> unitRst.gpCounterZero == $past(hwdata[PSR_BIT_CNT_ZERO]);
    endproperty
    a_wrCntZero: assert property (p_wrCntZero) else $error("counter zero reset wrong");

    property p_wrTwoWire;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitA && capabilityMaskTwo[PSR_BIT_TWOWIRE0])
            |=> unitRst.twoWireZero == $past(hwdata[PSR_BIT_TWOWIRE0]);
    endproperty
    a_wrTwoWire: assert property (p_wrTwoWire) else $error("two-wire reset wrong");

    property p_wrSync;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitA && capabilityMaskTwo[PSR_BIT_SYNCSER0])
            |=> unitRst.syncSerialZero == $past(hwdata[PSR_BIT_SYNCSER0]);
    endproperty
    a_wrSync: assert property (p_wrSync) else $error("sync serial reset wrong");

    property p_wrAsyncOne;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitA && capabilityMaskTwo[PSR_BIT_ASYNC1])
            |=> unitRst.asyncSerialOne == $past(hwdata[PSR_BIT_ASYNC1]);
    endproperty
    a_wrAsyncOne: assert property (p_wrAsyncOne) else $error("async one reset wrong");

    property p_wrAsyncZero;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitA && capabilityMaskTwo[PSR_BIT_ASYNC0])
            |=> unitRst.asyncSerialZero == $past(hwdata[PSR_BIT_ASYNC0]);
    endproperty
    a_wrAsyncZero: assert property (p_wrAsyncZero) else $error("async zero reset wrong");

    property p_wrPorts;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitB) |=> (portRst & $past(capabilityMaskFour[4:0]))
            == ($past(hwdata[4:0]) & $past(capabilityMaskFour[4:0]));
    endproperty
    a_wrPorts: assert property (p_wrPorts) else $error("port reset wrong");

    property p_pendSet;
        @(posedge core_clk) disable iff (rst)
        (addrPhase && hwrite) |=> wrPend_q;
    endproperty
    a_pendSet: assert property (p_pendSet) else $error("write address phase missed");

    property p_pendIdle;
        @(posedge core_clk) disable iff (rst)
        (hready && !(addrPhase && hwrite)) |=> !wrPend_q;
    endproperty
    a_pendIdle: assert property (p_pendIdle) else $error("write without request");

    property p_readB;
        @(posedge core_clk) disable iff (rst)
        (addrPhase && !hwrite && haddr == PSR_OFF_CTRL_B)
            |=> hrdata == $past(ctrlB_q);
    endproperty
    a_readB: assert property (p_readB) else $error("control B readback wrong");

    property p_readNone;
        @(posedge core_clk) disable iff (rst)
        (addrPhase && !hwrite && haddr != PSR_OFF_CTRL_A && haddr != PSR_OFF_CTRL_B)
            |=> hrdata == 32'h00000000;
    endproperty
    a_readNone: assert property (p_readNone) else $error("unmapped read not zero");

    property p_rdHold;
        @(posedge core_clk) disable iff (rst)
        !(addrPhase && !hwrite) |=> $stable(hrdata);
    endproperty
    a_rdHold: assert property (p_rdHold) else $error("read data moved");

    property p_wrNone;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && !hitA && !hitB) |=> $stable(ctrlA_q) && $stable(ctrlB_q);
    endproperty
    a_wrNone: assert property (p_wrNone) else $error("unmapped write landed");

    property p_onlyA;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitA) |=> $stable(ctrlB_q);
    endproperty
    a_onlyA: assert property (p_onlyA) else $error("control B hit by A write");

    property p_onlyB;
        @(posedge core_clk) disable iff (rst)
        (wrPend_q && hitB) |=> $stable(ctrlA_q);
    endproperty
    a_onlyB: assert property (p_onlyB) else $error("control A hit by B write");

    property p_rstClear;
        @(posedge core_clk)
        $fell(rst) |-> ctrlA_q == PSR_RESET_VALUE && ctrlB_q == PSR_RESET_VALUE
            && hrdata == 32'h00000000;
    endproperty
    a_rstClear: assert property (p_rstClear) else $error("state not clear after reset");
endmodule : psr_soft_reset_bank
`default_nettype wire

// [shared/psr_pkg.sv]
// Package for the peripheral soft-reset bank: register map, bus encodings and reset output types
`default_nettype none
package psr_pkg;
    localparam logic [11:0] PSR_OFF_CTRL_A = 12'h044;
    localparam logic [11:0] PSR_OFF_CTRL_B = 12'h048;
    localparam logic [31:0] PSR_RESET_VALUE = 32'h00000000;
    localparam int PSR_BIT_CMP_ZERO = 24;
    localparam int PSR_BIT_CNT_TWO = 18;
    localparam int PSR_BIT_CNT_ONE = 17;
    localparam int PSR_BIT_CNT_ZERO = 16;
    localparam int PSR_BIT_TWOWIRE0 = 12;
    localparam int PSR_BIT_SYNCSER0 = 4;
    localparam int PSR_BIT_ASYNC1 = 1;
    localparam int PSR_BIT_ASYNC0 = 0;
    localparam logic [31:0] PSR_IMPL_MASK_A = 32'h01071013;
    localparam logic [31:0] PSR_IMPL_MASK_B = 32'h0000001F;
    localparam logic [1:0] PSR_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] PSR_HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic comparatorZero;
        logic gpCounterTwo;
        logic gpCounterOne;
        logic gpCounterZero;
        logic twoWireZero;
        logic syncSerialZero;
        logic asyncSerialOne;
        logic asyncSerialZero;
    } psr_unit_rst_t;

    typedef struct packed {
        logic ioPortE;
        logic ioPortD;
        logic ioPortC;
        logic ioPortB;
        logic ioPortA;
    } psr_port_rst_t;
endpackage : psr_pkg
`default_nettype wire

// [verif/test_psr_soft_reset_bank.sv]
// Self-checking bench for the peripheral soft-reset bank
`timescale 1ns/1ns
`default_nettype none
module test_psr_soft_reset_bank
    import psr_pkg::*;
;
    logic core_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, capabilityMaskTwo, capabilityMaskFour, rd;
    psr_unit_rst_t unitRst;
    psr_port_rst_t portRst;
    int n_mismatch = 0;
    int checks_done = 0;
    int unitBits[8] = '{0, 1, 4, 12, 16, 17, 18, 24};
    // Single slave, so its readiness is the bus's
    assign hready = hreadyout;
    psr_soft_reset_bank psr_soft_reset_bank_i (.core_clk(core_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .capabilityMaskTwo(capabilityMaskTwo), .capabilityMaskFour(capabilityMaskFour),
        .unitRst(unitRst), .portRst(portRst));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Bounded wait for an edge with hready high
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            chk("hreadyout", 32'h1, {31'h0, hreadyout});
            stop_test();
        end
    endtask : wait_ready
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= PSR_HTRANS_NONSEQ;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
        @(posedge core_clk);
    endtask : xfer
    initial begin
        rst <= 1'b1;
        {hsel, hwrite, haddr, htrans, hwdata} <= '0;
        hsize <= PSR_HSIZE_WORD;
        capabilityMaskTwo <= 32'hFFFFFFFF;
        capabilityMaskFour <= 32'hFFFFFFFF;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        xfer(0, PSR_OFF_CTRL_A, 0);
        chk("ctrlA reset", PSR_RESET_VALUE, rd);
        xfer(0, PSR_OFF_CTRL_B, 0);
        chk("ctrlB reset", PSR_RESET_VALUE, rd);
        chk("resets idle", 32'h0, {19'h0, unitRst, portRst});
        foreach (unitBits[i]) begin
            xfer(1, PSR_OFF_CTRL_A, 32'h1 << unitBits[i]);
            chk("unitRst", 32'h1 << i, {24'h0, unitRst});
            xfer(0, PSR_OFF_CTRL_A, 0);
            chk("ctrlA bit", 32'h1 << unitBits[i], rd);
        end
        for (int i = 0; i < 5; i++) begin
            xfer(1, PSR_OFF_CTRL_B, 32'h1 << i);
            chk("portRst", 32'h1 << i, {27'h0, portRst});
        end
        xfer(1, PSR_OFF_CTRL_A, 32'hFFFFFFFF);
        xfer(1, PSR_OFF_CTRL_B, 32'hFFFFFFFF);
        xfer(0, PSR_OFF_CTRL_A, 0);
        chk("ctrlA ones", PSR_IMPL_MASK_A, rd);
        xfer(0, PSR_OFF_CTRL_B, 0);
        chk("ctrlB ones", PSR_IMPL_MASK_B, rd);
        // Absent units keep their old value
        capabilityMaskTwo <= 32'h00010001;
        capabilityMaskFour <= 32'h00000005;
        xfer(1, PSR_OFF_CTRL_A, 0);
        xfer(1, PSR_OFF_CTRL_B, 0);
        chk("unitRst masked", 32'hEE, {24'h0, unitRst});
        chk("portRst masked", 32'h1A, {27'h0, portRst});
        xfer(1, 12'h040, 32'hFFFFFFFF);
        xfer(0, 12'h040, 0);
        chk("unmapped", 32'h0, rd);
        capabilityMaskTwo <= 32'hFFFFFFFF;
        xfer(1, PSR_OFF_CTRL_A, 0);
        chk("unitRst clear", 32'h0, {24'h0, unitRst});
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        xfer(0, PSR_OFF_CTRL_B, 0);
        chk("ctrlB rereset", PSR_RESET_VALUE, rd);
        chk("portRst rereset", 32'h0, {27'h0, portRst});
        stop_test();
    end
endmodule : test_psr_soft_reset_bank
`default_nettype wire
